// >>> src/swr_host.sv
`include "swr_regs.svh"

// Summary of operation
// - Identity CRC uses x^8+x^5+x^4+1 in a shift-register accumulator.
// - CRC accumulator is cleared to zero before the first identity bit.
// - Bits enter CRC one by one, family LSB first, then 48 serial bits.
// - Shifting the stored CRC too must leave zero; nonzero means corrupt read.
// - After reset and presence, master issues exactly one of four identity commands; the code does not check presence, and does not refuse reads before it.
// - Every byte on the line is sent least significant bit first.
// - Master exchanges command at logic levels, then pulses programming voltage.
module swr_host
    import swr_pkg::*;
#(
    parameter int CW       = 20,
    parameter int RST_LOW  = `SWR_CYC(`SWR_RST_LOW_US),
    parameter int PRES     = `SWR_CYC_DN(`SWR_PRES_US),
    parameter int SLOT     = `SWR_CYC(`SWR_SLOT_US),
    parameter int LOW0     = `SWR_CYC(`SWR_LOW0_US),
    parameter int LOW1     = (SLOT * `SWR_LOW1_US) / `SWR_SLOT_US,
    parameter int SAMPLE   = (SLOT * `SWR_SAMPLE_US) / `SWR_SLOT_US,
    parameter int PROG     = `SWR_CYC(`SWR_PROG_US)
)
(
    input  wire logic        clock,
    input  wire logic        resetn,
    input  wire swr_cmd_type cmd,
    input  wire logic        cmd_valid,
    output logic             cmd_ready,
    output logic             done,
    output logic             refused,
    output logic             presence,
    output logic             rom_done,
    output logic             crc_ok,
    output logic [7:0]       rd_data,
    output logic             rd_valid,
    input  wire logic        rd_ready,
    input  wire logic        dq_in,
    output logic             dq_out,
    output logic             dq_oe,
    output logic             vpp_en
);

    localparam logic [CW-1:0] C_RST_LOW = CW'(RST_LOW);
    localparam logic [CW-1:0] C_RST_SMP = CW'(RST_LOW + PRES);
    localparam logic [CW-1:0] C_RST_END = CW'(2 * RST_LOW);
    localparam logic [CW-1:0] C_SLOT    = CW'(SLOT);
    localparam logic [CW-1:0] C_LOW0    = CW'(LOW0);
    localparam logic [CW-1:0] C_LOW1    = CW'(LOW1);
    localparam logic [CW-1:0] C_SAMPLE  = CW'(SAMPLE);
    localparam logic [CW-1:0] C_PROG    = CW'(PROG);

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
        logic fb;
        fb = c[0] ^ b;
        crc_step = (c >> 1) ^ (fb ? `SWR_CRC_POLY : 8'h00);
    endfunction : crc_step

    ////////////////////////////////////////////////////////////////////////////
    // Line input synchroniser
    logic dq_s1_r;
    logic dq_s2_r;

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            dq_s1_r <= 1'b1;
            dq_s2_r <= 1'b1;
        end
        else
        begin
            dq_s1_r <= dq_in;
            dq_s2_r <= dq_s1_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequencer
    swr_state_type   state_r,    state_nxt;
    swr_op_type      op_r,       op_nxt;
    logic [CW-1:0]   cnt_r,      cnt_nxt;
    logic [7:0]      shreg_r,    shreg_nxt;
    logic [2:0]      bit_r,      bit_nxt;
    logic [7:0]      crc_r,      crc_nxt;
    logic            pres_r,     pres_nxt;
    logic            pend_r,     pend_nxt;
    logic            romd_r,     romd_nxt;
    logic            done_r,     done_nxt;
    logic            ref_r,      ref_nxt;
    logic            oe_r,       oe_nxt;
    logic            vpp_r,      vpp_nxt;
    logic            rdy_r,      rdy_nxt;
    logic            crc_ok_r,   crc_ok_nxt;
    logic            accept;
    logic            is_rom;
    logic            push;
    logic            pop;
    logic [CW-1:0]   low_len;
    logic [1:0]      bcnt_r,     bcnt_nxt;
    logic [7:0]      b0_r,       b0_nxt;
    logic [7:0]      b1_r,       b1_nxt;
    logic            rv_r,       rv_nxt;

    assign accept  = cmd_valid && rdy_r;
    assign is_rom  = (cmd.data == `SWR_ROM_READ) || (cmd.data == `SWR_ROM_MATCH) ||
                     (cmd.data == `SWR_ROM_SEARCH) || (cmd.data == `SWR_ROM_SKIP);
    assign push    = (state_r == SWR_ST_SLOT) && (op_r == SWR_OP_READ) &&
                     (cnt_r == C_SLOT) && (bit_r == 3'h7);
    assign low_len = (op_r == SWR_OP_WRITE && !shreg_r[0]) ? C_LOW0 : C_LOW1;

    always_comb
    begin
        state_nxt = state_r;
        op_nxt    = op_r;
        cnt_nxt   = cnt_r + CW'(1);
        shreg_nxt = shreg_r;
        bit_nxt   = bit_r;
        crc_nxt   = crc_r;
        pres_nxt  = pres_r;
        pend_nxt  = pend_r;
        romd_nxt  = romd_r;
        done_nxt  = 1'b0;
        ref_nxt   = 1'b0;
        oe_nxt    = 1'b0;
        vpp_nxt   = 1'b0;
        case (state_r)
            SWR_ST_IDLE:
            begin
                cnt_nxt = '0;
                if (accept)
                begin
                    op_nxt    = cmd.op;
                    shreg_nxt = cmd.data;
                    bit_nxt   = 3'h0;
                    if (cmd.crc_clr)
                        crc_nxt = `SWR_CRC_INIT;
                    case (cmd.op)
                        SWR_OP_RESET:
                        begin
                            state_nxt = SWR_ST_RESET;
                            oe_nxt    = 1'b1;
                        end
                        SWR_OP_WRITE:
                        begin
                            if ((pend_r && !is_rom) || (!pend_r && !romd_r))
                                ref_nxt = 1'b1;
                            else
                            begin
                                state_nxt = SWR_ST_SLOT;
                                oe_nxt    = 1'b1;
                                if (pend_r)
                                begin
                                    pend_nxt = 1'b0;
                                    romd_nxt = 1'b1;
                                end
                            end
                        end
                        SWR_OP_READ:
                        begin
                            state_nxt = SWR_ST_SLOT;
                            oe_nxt    = 1'b1;
                        end
                        default:
                        begin
                            if (!romd_r)
                                ref_nxt = 1'b1;
                            else
                            begin
                                state_nxt = SWR_ST_PROG;
                                vpp_nxt   = 1'b1;
                            end
                        end
                    endcase
                end
            end
            SWR_ST_RESET:
            begin
                oe_nxt = (cnt_nxt < C_RST_LOW);
                if (cnt_r == C_RST_SMP)
                    pres_nxt = !dq_s2_r;
                if (cnt_r == C_RST_END)
                begin
                    state_nxt = SWR_ST_IDLE;
                    oe_nxt    = 1'b0;
                    done_nxt  = 1'b1;
                    pend_nxt  = 1'b1;
                    romd_nxt  = 1'b0;
                end
            end
            SWR_ST_SLOT:
            begin
                oe_nxt = (cnt_nxt < low_len);
                if (op_r == SWR_OP_READ && cnt_r == C_SAMPLE)
                begin
                    shreg_nxt = {dq_s2_r, shreg_r[7:1]};
                    crc_nxt   = crc_step(crc_r, dq_s2_r);
                end
                // Write shift at slot end, so the low time holds for the whole slot
                if (op_r == SWR_OP_WRITE && cnt_r == C_SLOT)
                begin
                    crc_nxt   = crc_step(crc_r, shreg_r[0]);
                    shreg_nxt = {1'b1, shreg_r[7:1]};
                end
                if (cnt_r == C_SLOT)
                begin
                    cnt_nxt = '0;
                    bit_nxt = bit_r + 3'h1;
                    oe_nxt  = (bit_r != 3'h7);
                    if (bit_r == 3'h7)
                    begin
                        state_nxt = SWR_ST_IDLE;
                        done_nxt  = 1'b1;
                    end
                end
            end
            SWR_ST_PROG:
            begin
                vpp_nxt = (cnt_nxt < C_PROG);
                if (cnt_r == C_PROG)
                begin
                    state_nxt = SWR_ST_IDLE;
                    done_nxt  = 1'b1;
                end
            end
            default:
            begin
                state_nxt = SWR_ST_IDLE;
            end
        endcase
        rdy_nxt = (state_nxt == SWR_ST_IDLE) && !accept && (bcnt_nxt != 2'h2);
        crc_ok_nxt = (crc_nxt == 8'h00);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            state_r <= SWR_ST_IDLE;
            op_r    <= SWR_OP_RESET;
            cnt_r   <= '0;
            shreg_r <= 8'h00;
            bit_r   <= 3'h0;
            crc_r   <= 8'h00;
            pres_r  <= 1'b0;
            pend_r  <= 1'b0;
            romd_r  <= 1'b0;
            done_r  <= 1'b0;
            ref_r   <= 1'b0;
            oe_r    <= 1'b0;
            vpp_r   <= 1'b0;
            rdy_r   <= 1'b0;
            crc_ok_r <= 1'b1;
        end
        else
        begin
            state_r <= state_nxt;
            op_r    <= op_nxt;
            cnt_r   <= cnt_nxt;
            shreg_r <= shreg_nxt;
            bit_r   <= bit_nxt;
            crc_r   <= crc_nxt;
            pres_r  <= pres_nxt;
            pend_r  <= pend_nxt;
            romd_r  <= romd_nxt;
            done_r  <= done_nxt;
            ref_r   <= ref_nxt;
            oe_r    <= oe_nxt;
            vpp_r   <= vpp_nxt;
            rdy_r   <= rdy_nxt;
            crc_ok_r <= crc_ok_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Two-entry read buffer, head in b0
    assign pop = rv_r && rd_ready;

    always_comb
    begin
        bcnt_nxt = bcnt_r;
        b0_nxt   = b0_r;
        b1_nxt   = b1_r;
        if (pop)
        begin
            b0_nxt   = b1_r;
            bcnt_nxt = bcnt_r - 2'h1;
        end
        if (push)
        begin
            if (bcnt_nxt == 2'h0)
                b0_nxt = shreg_nxt;
            else
                b1_nxt = shreg_nxt;
            bcnt_nxt = bcnt_nxt + 2'h1;
        end
        rv_nxt = (bcnt_nxt != 2'h0);
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            bcnt_r <= 2'h0;
            b0_r   <= 8'h00;
            b1_r   <= 8'h00;
            rv_r   <= 1'b0;
        end
        else
        begin
            bcnt_r <= bcnt_nxt;
            b0_r   <= b0_nxt;
            b1_r   <= b1_nxt;
            rv_r   <= rv_nxt;
        end
    end

    assign cmd_ready = rdy_r;
    assign done      = done_r;
    assign refused   = ref_r;
    assign presence  = pres_r;
    assign rom_done  = romd_r;
    assign crc_ok    = crc_ok_r;
    assign rd_data   = b0_r;
    assign rd_valid  = rv_r;
    assign dq_out    = 1'b0;
    assign dq_oe     = oe_r;
    assign vpp_en    = vpp_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    sequence s_acc(swr_op_type o);
        accept && cmd.op == o;
    endsequence

    property p_rst_low;
        s_acc(SWR_OP_RESET) |=> dq_oe && state_r == SWR_ST_RESET;
    endproperty
    a_rst_low: assert property (p_rst_low) else $error("reset not driven low");

    property p_rom_first;
        s_acc(SWR_OP_WRITE) ##0 (pend_r && !is_rom) |=> refused && !dq_oe;
    endproperty
    a_rom_first: assert property (p_rom_first) else $error("non rom byte sent");

    property p_mem_gate;
        s_acc(SWR_OP_PROG) ##0 !rom_done |=> refused && !vpp_en;
    endproperty
    a_mem_gate: assert property (p_mem_gate) else $error("prog before rom");

    property p_crc_clr;
        accept && cmd.crc_clr |=> crc_r == 8'h00;
    endproperty
    a_crc_clr: assert property (p_crc_clr) else $error("crc not cleared");

    property p_crc_step;
        state_r == SWR_ST_SLOT && op_r == SWR_OP_READ && cnt_r == C_SAMPLE
            |=> crc_r == crc_step($past(crc_r), $past(dq_s2_r));
    endproperty
    a_crc_step: assert property (p_crc_step) else $error("crc step wrong");

    property p_lsb_first;
        state_r == SWR_ST_SLOT && cnt_r == C_LOW1
            |-> dq_oe == (op_r == SWR_OP_WRITE && !shreg_r[0]);
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong");

    property p_full_stall;
        bcnt_r == 2'h2 |-> !cmd_ready;
    endproperty
    a_full_stall: assert property (p_full_stall) else $error("ready while full");

    property p_vpp;
        s_acc(SWR_OP_PROG) ##0 rom_done |=> vpp_en ##1 vpp_en;
    endproperty
    a_vpp: assert property (p_vpp) else $error("prog pulse missing");

    property p_pres_done;
        state_r == SWR_ST_RESET && cnt_r == C_RST_END
            |=> done && !rom_done && pend_r && (cmd_ready || bcnt_r == 2'h2);
    endproperty
    a_pres_done: assert property (p_pres_done) else $error("reset end wrong");

endmodule : swr_host

// >>> src/swr_regs.svh
`ifndef SWR_REGS_SVH
`define SWR_REGS_SVH
// Clock period
`define SWR_CLK_NS        4
// Link timing, microseconds
`define SWR_RST_LOW_US    480
`define SWR_PRES_US       70
`define SWR_SLOT_US       70
`define SWR_LOW0_US       60
`define SWR_LOW1_US       6
`define SWR_SAMPLE_US     15
`define SWR_PROG_US       480
// Derived cycle counts
`define SWR_CYC(us)       (((us) * 1000 + `SWR_CLK_NS - 1) / `SWR_CLK_NS)
`define SWR_CYC_DN(us)    (((us) * 1000) / `SWR_CLK_NS)
// Identity CRC, reflected form of x^8 + x^5 + x^4 + 1
`define SWR_CRC_POLY      8'h8c
`define SWR_CRC_INIT      8'h00
// Identity-stage command codes
`define SWR_ROM_READ      8'h33
`define SWR_ROM_MATCH     8'h55
`define SWR_ROM_SEARCH    8'hf0
`define SWR_ROM_SKIP      8'hcc
`define SWR_BUF_DEPTH     2
`endif

// >>> src/swr_pkg.sv
package swr_pkg;

    typedef enum logic [1:0]
    {
        SWR_OP_RESET = 2'h0,
        SWR_OP_WRITE = 2'h1,
        SWR_OP_READ  = 2'h2,
        SWR_OP_PROG  = 2'h3
    } swr_op_type;

    typedef struct packed
    {
        swr_op_type  op;
        logic [7:0]  data;
        logic        crc_clr;
    } swr_cmd_type;

    typedef enum logic [3:0]
    {
        SWR_ST_IDLE  = 4'h1,
        SWR_ST_RESET = 4'h2,
        SWR_ST_SLOT  = 4'h4,
        SWR_ST_PROG  = 4'h8
    } swr_state_type;

endpackage : swr_pkg

// >>> dv/swr_dev_model.sv
module swr_dev_model
#(
    parameter logic [63:0] IDENT = 64'h0
)
(
    input  wire logic       clock,
    input  wire logic       line,
    input  wire logic       vpp,
    input  wire logic       corrupt,
    output logic            pull,
    output logic [7:0]      last_byte,
    output logic [7:0]      mem
);
    timeunit 1ns;
    timeprecision 1ps;

    int          low_cnt  = 0;
    int          pres_cnt = 0;
    int          send_cnt = 0;
    int          idx      = 0;
    int          nbits    = 0;
    logic        prev     = 1'b1;
    logic        mine     = 1'b0;
    logic        sending  = 1'b0;
    logic        rom_ok   = 1'b0;
    logic        vpp_d    = 1'b0;
    logic [7:0]  rx       = 8'h00;
    logic [7:0]  rx_n;
    logic [7:0]  scratch  = 8'hff;
    logic [63:0] id_word;

    initial mem = 8'hff;
    initial last_byte = 8'h00;
    assign id_word = IDENT ^ {7'h0, corrupt, 56'h0};
    assign rx_n    = {low_cnt < 8, rx[7:1]};
    assign pull    = (pres_cnt != 0 && pres_cnt <= 20) || send_cnt != 0;

    ////////////////////////////////////////////////////////////////////////////////
    always @(posedge clock)
    begin
        prev  <= line;
        vpp_d <= vpp;
        if (pres_cnt != 0) pres_cnt <= pres_cnt - 1;
        if (send_cnt != 0) send_cnt <= send_cnt - 1;
        if (pull) mine <= 1'b1;
        if (!line) low_cnt <= low_cnt + 1;
        if (prev && !line && sending && !pull)
        begin
            if (!id_word[idx]) send_cnt <= 12;
            idx     <= idx + 1;
            sending <= idx != 63;
        end
        if (!prev && line)
        begin
            low_cnt <= 0;
            mine    <= 1'b0;
            if (low_cnt > 30)
            begin
                pres_cnt <= 23;
                rom_ok   <= 1'b0;
                sending  <= 1'b0;
                nbits    <= 0;
            end
            else if (!mine && !sending)
            begin
                rx    <= rx_n;
                nbits <= (nbits == 7) ? 0 : nbits + 1;
                if (nbits == 7)
                begin
                    last_byte <= rx_n;
                    if (!rom_ok)
                    begin
                        rom_ok  <= rx_n inside {8'h33, 8'h55, 8'hf0, 8'hcc};
                        sending <= rx_n == 8'h33;
                        idx     <= 0;
                    end
                    else scratch <= rx_n;
                end
            end
        end
        if (vpp && !vpp_d && rom_ok) mem <= mem & scratch;
    end
endmodule : swr_dev_model

// >>> dv/swr_host_test.sv
`include "swr_regs.svh"
module swr_host_test import swr_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [7:0]  FAMILY = 8'h5a; // Arbitrary value
    localparam logic [47:0] SERIAL = 48'h0123_4567_89ab; // Arbitrary value
    localparam logic [7:0]  CODES [4] = '{8'h33, 8'h55, 8'hf0, 8'hcc};

    function automatic logic [7:0] crc8(input logic [55:0] d);
        logic [7:0] c;
        logic       fb;
        c = `SWR_CRC_INIT;
        for (int i = 0; i < 56; i++)
        begin
            fb = c[0] ^ d[i];
            c  = (c >> 1) ^ (fb ? `SWR_CRC_POLY : 8'h00);
        end
        return c;
    endfunction : crc8

    localparam logic [63:0] IDENT = {crc8({SERIAL, FAMILY}), SERIAL, FAMILY};

    logic        clock, resetn, cmd_valid, cmd_ready, done, refused, presence, rom_done;
    logic        crc_ok, rd_valid, rd_ready, dq, dq_out, dq_oe, vpp_en, dev_pull, corrupt;
    logic [7:0]  rd_data, last_byte, mem;
    swr_cmd_type cmd;
    int          n_errors, total_checks;

    assign dq = !(dq_oe || dev_pull);

    swr_host #(.RST_LOW(40), .PRES(8), .SLOT(28), .LOW0(15), .PROG(10))
    i_swr_host (.clock(clock), .resetn(resetn), .cmd(cmd), .cmd_valid(cmd_valid),
        .cmd_ready(cmd_ready), .done(done), .refused(refused), .presence(presence),
        .rom_done(rom_done), .crc_ok(crc_ok), .rd_data(rd_data), .rd_valid(rd_valid),
        .rd_ready(rd_ready), .dq_in(dq), .dq_out(dq_out), .dq_oe(dq_oe), .vpp_en(vpp_en));

    swr_dev_model #(.IDENT(IDENT))
    i_swr_dev_model (.clock(clock), .line(dq), .vpp(vpp_en), .corrupt(corrupt),
        .pull(dev_pull), .last_byte(last_byte), .mem(mem));

    always #2 clock = ~clock;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("Error at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic do_op(input swr_op_type op, input logic [7:0] d, input logic clr,
                         input logic exp_ref);
        int n;
        n = 0;
        cmd       <= '{op, d, clr};
        cmd_valid <= 1'b1;
        do @(posedge clock); while (cmd_ready !== 1'b1 && n++ < 5000);
        cmd_valid <= 1'b0;
        do @(posedge clock); while (done !== 1'b1 && refused !== 1'b1 && n++ < 5000);
        check(n < 5000 && refused === exp_ref, "operation outcome wrong");
    endtask : do_op

    task automatic pop(input logic [7:0] exp);
        int n;
        n = 0;
        do @(posedge clock); while (rd_valid !== 1'b1 && n++ < 100);
        check(rd_data === exp, "read byte wrong");
        rd_ready <= 1'b1;
        @(posedge clock);
        rd_ready <= 1'b0;
    endtask : pop

    task automatic report_and_stop;
        $display("Checks %0d, errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : report_and_stop

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_refuse;
        do_op(SWR_OP_WRITE, `SWR_ROM_READ, 1'b0, 1'b1);
        do_op(SWR_OP_PROG, 8'h00, 1'b0, 1'b1);
        do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
        check(presence === 1'b1, "no presence seen");
        check(dq_out === 1'b0 && dq_oe === 1'b0, "line not released after reset");
        do_op(SWR_OP_WRITE, 8'ha5, 1'b0, 1'b1);
        check(rom_done === 1'b0, "identity stage wrongly done");
        $display("t_refuse finished");
    endtask : t_refuse

    task automatic t_rom_codes;
        for (int i = 0; i < 4; i++)
        begin
            do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
            do_op(SWR_OP_WRITE, CODES[i], 1'b0, 1'b0);
            check(rom_done === 1'b1 && last_byte === CODES[i], "command bits wrong");
            do_op(SWR_OP_WRITE, 8'h99, 1'b0, 1'b0);
        end
        $display("t_rom_codes finished");
    endtask : t_rom_codes

    task automatic t_read_id(input logic bad);
        logic [63:0] e;
        e = IDENT ^ {7'h0, bad, 56'h0};
        do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
        do_op(SWR_OP_WRITE, `SWR_ROM_READ, 1'b0, 1'b0);
        for (int i = 0; i < 8; i++)
        begin
            do_op(SWR_OP_READ, 8'h00, i == 0, 1'b0);
            if (i == 1)
            begin
                repeat (2) @(posedge clock);
                check(cmd_ready === 1'b0, "full buffer still takes commands");
            end
            if (i % 2 == 1)
            begin
                pop(e[8*(i-1) +: 8]);
                pop(e[8*i +: 8]);
            end
        end
        check(crc_ok === !bad, "identity check result wrong");
        $display("t_read_id finished");
    endtask : t_read_id

    task automatic t_prog;
        do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
        do_op(SWR_OP_WRITE, `SWR_ROM_SKIP, 1'b0, 1'b0);
        do_op(SWR_OP_WRITE, 8'h3c, 1'b0, 1'b0);
        do_op(SWR_OP_PROG, 8'h00, 1'b0, 1'b0);
        check(mem === 8'h3c, "first programming wrong");
        do_op(SWR_OP_WRITE, 8'hf5, 1'b0, 1'b0);
        do_op(SWR_OP_PROG, 8'h00, 1'b0, 1'b0);
        check(mem === 8'h34, "cleared bits came back");
        $display("t_prog finished");
    endtask : t_prog

    task automatic t_abort;
        do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
        do_op(SWR_OP_WRITE, `SWR_ROM_SKIP, 1'b0, 1'b0);
        do_op(SWR_OP_RESET, 8'h00, 1'b0, 1'b0);
        check(rom_done === 1'b0, "identity stage kept over reset");
        do_op(SWR_OP_PROG, 8'h00, 1'b0, 1'b1);
        check(mem === 8'h34, "memory changed by refused program");
        $display("t_abort finished");
    endtask : t_abort

    ////////////////////////////////////////////////////////////////////////////////
    initial
    begin
        clock        = 1'b0;
        resetn       = 1'b0;
        cmd          = '0;
        cmd_valid    = 1'b0;
        rd_ready     = 1'b0;
        corrupt      = 1'b0;
        n_errors     = 0;
        total_checks = 0;
        repeat (8) @(posedge clock);
        resetn <= 1'b1;
        t_refuse;
        t_rom_codes;
        t_read_id(1'b0);
        corrupt <= 1'b1;
        t_read_id(1'b1);
        corrupt <= 1'b0;
        t_prog;
        t_abort;
        report_and_stop;
    end

    initial
    begin
        #100000;
        n_errors++;
        report_and_stop;
    end
endmodule : swr_host_test
